// File: design/csp_serial_port.sv
`timescale 1ns/1ns
`include "csp_map.svh"
module csp_serial_port
  import csp_pkg::*;
#(
  parameter int SCLK_HALF = `CSP_SCLK_HALF,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_reset_pin_n,
  input  wire logic        i_power_down_n,
  input  wire logic        i_master_sel,
  input  wire logic        i_sclk,
  input  wire logic        i_frame_sync_n,
  input  wire logic        i_din,
  input  wire logic        i_secondary_request_in,
  input  wire logic [15:0] i_adc_sample,
  input  wire logic        i_dac_ready,
  output logic             o_sclk,
  output logic             o_sclk_oe,
  output logic             o_frame_sync_n,
  output logic             o_frame_sync_oe,
  output logic             o_dout,
  output logic             o_dout_oe,
  output logic             o_delayed_frame_sync_n,
  output logic      [15:0] o_dac_data,
  output logic             o_dac_valid,
  output logic             o_dac_overrun,
  output logic             o_soft_power_down,
  output logic             o_analog_enable
);
  import csp_pkg::*;

  // Pin synchronisers: bit 0 sclk, 1 sync, 2 din, 3 request, 4 pdown, 5 reset, 6 master
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [6:0] sync3;
  logic [6:0] filt;
  logic [6:0] filt_d;
  logic [6:0] next_filt;

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      next_filt[i] = (sync2[i] == sync3[i]) ? sync2[i] : filt[i];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sync1  <= `CSP_SYNC_INIT;
      sync2  <= `CSP_SYNC_INIT;
      sync3  <= `CSP_SYNC_INIT;
      filt   <= `CSP_SYNC_INIT;
      filt_d <= `CSP_SYNC_INIT;
    end else begin
      sync1  <= {i_master_sel, i_reset_pin_n, i_power_down_n, i_secondary_request_in,
                 i_din, i_frame_sync_n, i_sclk};
      sync2  <= sync1;
      sync3  <= sync2;
      filt   <= next_filt;
      filt_d <= filt;
    end
  end

  function automatic logic word_bit(input logic [15:0] w, input logic [3:0] idx);
    return w[4'hf - idx];
  endfunction

  logic             master;
  logic             hpd;
  logic             spd;
  logic             int_rst;
  logic             drive_ok;
  logic             fifo_wr_ready;
  logic             fifo_rd_valid;
  logic [15:0]      fifo_rd_data;
  logic             fifo_rd_ready;

  logic [2:0]       rst_cnt;
  logic [7:0]       div_cnt;
  logic [7:0]       bit_pos;
  logic             fs_q;
  logic             fs_d;
  logic             fall_q;
  csp_frame_t       frame_st;
  csp_kind_t        kind;
  logic             sec_pending;
  logic             sw_req;
  logic [15:0]      rx;
  logic [4:0]       bit_cnt;
  logic [15:0]      tx_word;
  logic [3:0]       tx_idx;
  logic [5:0]       fsd_cnt;
  logic [4:0]       fsd_len;
  logic [7:0]       regs [1:7];
  logic             push;
  logic [15:0]      push_data;

  logic [2:0]       next_rst_cnt;
  logic [7:0]       next_div_cnt;
  logic [7:0]       next_bit_pos;
  logic             next_sclk;
  logic             next_fs_q;
  logic             next_fs_d;
  logic             next_fall_q;
  csp_frame_t       next_frame_st;
  csp_kind_t        next_kind;
  logic             next_sec_pending;
  logic             next_sw_req;
  logic [15:0]      next_rx;
  logic [4:0]       next_bit_cnt;
  logic [15:0]      next_tx_word;
  logic [3:0]       next_tx_idx;
  logic             next_dout;
  logic             next_dout_oe;
  logic             next_fsd;
  logic [5:0]       next_fsd_cnt;
  logic [4:0]       next_fsd_len;
  logic [7:0]       next_regs [1:7];
  logic             next_push;
  logic [15:0]      next_push_data;
  logic             next_overrun;
  logic             next_out_valid;
  logic [15:0]      next_out_data;

  // Event decode, scratch values of the core process
  logic             tick;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             cap;
  logic             fs_level;
  logic             fs_fall;
  logic             fs_rise;
  logic [7:0]       pos;
  logic [15:0]      w;
  logic [7:0]       rx8;
  logic [4:0]       addr;
  logic [5:0]       fsd_m;

  assign master   = filt[6];
  assign hpd      = !filt[4];
  assign spd      = regs[1][`CSP_C1_SOFT_PDOWN];
  assign int_rst  = (rst_cnt != 3'h0) || !filt[5];
  assign drive_ok = !spd && (master ||
                    (regs[3][`CSP_C3_SLAVES_HI:`CSP_C3_SLAVES_LO] != 2'h0));
  assign fifo_rd_ready = !o_dac_valid || i_dac_ready;

  always_comb begin
    next_rst_cnt     = (rst_cnt != 3'h0) ? rst_cnt - 3'h1 : 3'h0;
    next_div_cnt     = div_cnt;
    next_bit_pos     = bit_pos;
    next_sclk        = o_sclk;
    next_fs_q        = fs_q;
    next_fs_d        = fs_d;
    next_fall_q      = 1'b0;
    next_frame_st    = frame_st;
    next_kind        = kind;
    next_sec_pending = sec_pending;
    next_sw_req      = sw_req;
    next_rx          = rx;
    next_bit_cnt     = bit_cnt;
    next_tx_word     = tx_word;
    next_tx_idx      = tx_idx;
    next_dout        = o_dout;
    next_dout_oe     = o_dout_oe;
    next_fsd         = o_delayed_frame_sync_n;
    next_fsd_cnt     = fsd_cnt;
    next_fsd_len     = fsd_len;
    next_regs        = regs;
    next_push        = 1'b0;
    next_push_data   = push_data;
    next_overrun     = o_dac_overrun;
    next_out_valid   = o_dac_valid;
    next_out_data    = o_dac_data;
    tick      = 1'b0;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cap       = 1'b0;
    fs_level  = 1'b1;
    fs_fall   = 1'b0;
    fs_rise   = 1'b0;
    pos       = 8'h00;
    w         = 16'h0000;
    rx8       = 8'h00;
    addr      = 5'h00;
    fsd_m     = regs[3][`CSP_C3_FSD_HI:`CSP_C3_FSD_LO];

    if (fifo_rd_ready) begin
      next_out_valid = fifo_rd_valid;
      next_out_data  = fifo_rd_data;
    end

    if (!filt[5]) begin
      next_rst_cnt = 3'(`CSP_RST_MIN_MCLK);
    end

    if (int_rst) begin
      next_div_cnt     = 8'h00;
      next_bit_pos     = 8'hff;
      next_sclk        = 1'b0;
      next_fs_q        = 1'b1;
      next_fs_d        = 1'b1;
      next_frame_st    = CSP_IDLE;
      next_kind        = CSP_PRIMARY;
      next_sec_pending = 1'b0;
      next_sw_req      = 1'b0;
      next_rx          = 16'h0000;
      next_bit_cnt     = 5'h00;
      next_tx_word     = 16'h0000;
      next_tx_idx      = 4'h0;
      next_dout        = 1'b0;
      next_dout_oe     = 1'b0;
      next_fsd         = 1'b1;
      next_fsd_cnt     = 6'h00;
      next_fsd_len     = 5'h00;
      for (int i = 1; i < 8; i++) begin
        next_regs[i] = `CSP_REG_RESET;
      end
      next_overrun     = 1'b0;
      next_out_valid   = 1'b0;
    end else if (!hpd) begin
      // Master shift clock from the master clock divider
      if (master) begin
        if (div_cnt == 8'(SCLK_HALF - 1)) begin
          next_div_cnt = 8'h00;
          next_sclk    = !o_sclk;
          tick         = 1'b1;
        end else begin
          next_div_cnt = div_cnt + 8'h01;
        end
      end
      sclk_rise = master ? (tick && !o_sclk) : (filt[0] && !filt_d[0]);
      sclk_fall = master ? (tick && o_sclk) : (!filt[0] && filt_d[0]);
      // Own sclk skips the synchroniser but din does not, so a master captures a clock late
      next_fall_q = master && sclk_fall;
      cap         = master ? fall_q : sclk_fall;

      // Master sync: primary slot at 0, secondary slot only when asked
      if (master && sclk_rise) begin
        pos          = bit_pos + 8'h01;
        next_bit_pos = pos;
        if (pos < 8'(`CSP_WORD_BITS)) begin
          next_fs_q = 1'b0;
        end else if (pos == `CSP_SEC_SLOT) begin
          next_fs_q = !sec_pending;
        end else if (pos > `CSP_SEC_SLOT && pos < `CSP_SEC_SLOT_END) begin
          next_fs_q = fs_q;
        end else begin
          next_fs_q = 1'b1;
        end
      end
      if (!master) begin
        next_fs_q = 1'b1;
      end

      // A slave times itself from the sync pin, fed by the upstream delayed sync
      fs_level  = master ? fs_q : filt[1];
      next_fs_d = fs_level;
      fs_fall   = fs_d && !fs_level;
      fs_rise   = !fs_d && fs_level;

      if (fs_fall) begin
        next_frame_st = CSP_SHIFT;
        next_kind     = sec_pending ? CSP_SECONDARY : CSP_PRIMARY;
        next_bit_cnt  = 5'h00;
        next_tx_idx   = 4'h0;
        next_tx_word  = sec_pending ? {master, 15'h0000} :
                                      {i_adc_sample[15:1], master};
        next_dout     = word_bit(next_tx_word, 4'h0);
        next_dout_oe  = drive_ok;
        if (sec_pending) begin
          next_sec_pending = 1'b0;
        end
        if (!spd) begin
          if (fsd_m > `CSP_FSD_MIN_DELAY) begin
            next_fsd_cnt = fsd_m;
          end else begin
            next_fsd = 1'b0;
          end
        end
      end else begin
        if (frame_st == CSP_SHIFT && sclk_rise && tx_idx != 4'hf) begin
          next_tx_idx = tx_idx + 4'h1;
          next_dout   = word_bit(tx_word, next_tx_idx);
        end
        if (frame_st == CSP_SHIFT && cap) begin
          next_rx      = {rx[14:0], filt[2]};
          next_bit_cnt = bit_cnt + 5'h01;
          rx8          = next_rx[7:0];
          addr         = rx8[4:0];
          if (kind == CSP_SECONDARY && bit_cnt == 5'h07) begin
            next_tx_word[7:0] = (rx8[5] && addr != `CSP_ADDR_NOP &&
                                 addr <= `CSP_ADDR_LAST) ? regs[addr[2:0]] : 8'h00;
          end
          if (bit_cnt == 5'(`CSP_WORD_BITS - 1)) begin
            w             = next_rx;
            addr          = w[`CSP_SEC_ADDR_HI:`CSP_SEC_ADDR_LO];
            next_frame_st = CSP_DONE;
            if (kind == CSP_PRIMARY && !spd) begin
              next_sw_req    = regs[1][`CSP_C1_FMT_15P1] && w[0];
              next_push_data = regs[1][`CSP_C1_FMT_15P1] ? {w[15:1], 1'b0} : w;
              if (fifo_wr_ready) begin
                next_push = 1'b1;
              end else begin
                next_overrun = 1'b1;
              end
            end else if (kind == CSP_SECONDARY && !w[`CSP_SEC_RW_BIT] &&
                         addr != `CSP_ADDR_NOP && addr <= `CSP_ADDR_LAST) begin
              if (addr == `CSP_ADDR_CTRL1 && w[`CSP_C1_SOFT_RESET]) begin
                next_rst_cnt = 3'(`CSP_RST_MIN_MCLK);
              end else begin
                next_regs[addr[2:0]] = w[7:0];
              end
            end
          end
        end
        if (fs_rise) begin
          next_dout_oe  = 1'b0;
          next_frame_st = CSP_IDLE;
          if (kind == CSP_PRIMARY) begin
            next_sec_pending = filt[3] || sw_req;
            next_sw_req      = 1'b0;
          end
          if (fsd_len == 5'h00 && fsd_cnt == 6'h00) begin
            next_fsd = 1'b1;
          end
        end
      end

      // Delayed sync for the next device in the chain
      if (sclk_rise && !fs_fall) begin
        if (fsd_cnt != 6'h00) begin
          next_fsd_cnt = fsd_cnt - 6'h01;
          if (fsd_cnt == 6'h01) begin
            next_fsd     = 1'b0;
            next_fsd_len = 5'(`CSP_WORD_BITS);
          end
        end else if (fsd_len != 5'h00) begin
          next_fsd_len = fsd_len - 5'h01;
          if (fsd_len == 5'h01) begin
            next_fsd = 1'b1;
          end
        end
      end
      if (spd) begin
        next_fsd     = 1'b1;
        next_fsd_cnt = 6'h00;
        next_fsd_len = 5'h00;
        next_dout_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rst_cnt                <= 3'h0;
      div_cnt                <= 8'h00;
      bit_pos                <= 8'hff;
      o_sclk                 <= 1'b0;
      fs_q                   <= 1'b1;
      fs_d                   <= 1'b1;
      fall_q                 <= 1'b0;
      frame_st               <= CSP_IDLE;
      kind                   <= CSP_PRIMARY;
      sec_pending            <= 1'b0;
      sw_req                 <= 1'b0;
      rx                     <= 16'h0000;
      bit_cnt                <= 5'h00;
      tx_word                <= 16'h0000;
      tx_idx                 <= 4'h0;
      o_dout                 <= 1'b0;
      o_dout_oe              <= 1'b0;
      o_delayed_frame_sync_n <= 1'b1;
      fsd_cnt                <= 6'h00;
      fsd_len                <= 5'h00;
      for (int i = 1; i < 8; i++) begin
        regs[i] <= `CSP_REG_RESET;
      end
      push                   <= 1'b0;
      push_data              <= 16'h0000;
      o_dac_overrun          <= 1'b0;
      o_dac_valid            <= 1'b0;
      o_dac_data             <= 16'h0000;
      o_sclk_oe              <= 1'b0;
      o_frame_sync_n         <= 1'b1;
      o_frame_sync_oe        <= 1'b0;
      o_soft_power_down      <= 1'b0;
      o_analog_enable        <= 1'b0;
    end else begin
      rst_cnt                <= next_rst_cnt;
      div_cnt                <= next_div_cnt;
      bit_pos                <= next_bit_pos;
      o_sclk                 <= next_sclk;
      fs_q                   <= next_fs_q;
      fs_d                   <= next_fs_d;
      fall_q                 <= next_fall_q;
      frame_st               <= next_frame_st;
      kind                   <= next_kind;
      sec_pending            <= next_sec_pending;
      sw_req                 <= next_sw_req;
      rx                     <= next_rx;
      bit_cnt                <= next_bit_cnt;
      tx_word                <= next_tx_word;
      tx_idx                 <= next_tx_idx;
      o_dout                 <= next_dout;
      o_dout_oe              <= next_dout_oe;
      o_delayed_frame_sync_n <= next_fsd;
      fsd_cnt                <= next_fsd_cnt;
      fsd_len                <= next_fsd_len;
      regs                   <= next_regs;
      push                   <= next_push;
      push_data              <= next_push_data;
      o_dac_overrun          <= next_overrun;
      o_dac_valid            <= next_out_valid;
      o_dac_data             <= next_out_data;
      // Pin drivers follow the filtered mode pin; a change mid-frame is not guarded
      o_sclk_oe              <= next_filt[6];
      o_frame_sync_n         <= next_fs_q;
      o_frame_sync_oe        <= next_filt[6];
      o_soft_power_down      <= next_regs[1][`CSP_C1_SOFT_PDOWN];
      o_analog_enable        <= !next_regs[1][`CSP_C1_SOFT_PDOWN] && next_filt[4];
    end
  end

  csp_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_dac_fifo (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_clear    (int_rst),
    .i_wr_valid (push),
    .o_wr_ready (fifo_wr_ready),
    .i_wr_data  (push_data),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (fifo_rd_ready),
    .o_rd_data  (fifo_rd_data)
  );
endmodule

// File: design/csp_map.svh
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH

// Control register addresses
`define CSP_ADDR_NOP      5'h00
`define CSP_ADDR_CTRL1    5'h01
`define CSP_ADDR_CTRL3    5'h03
`define CSP_ADDR_LAST     5'h07

// Control register 1 fields
`define CSP_C1_SOFT_RESET 7
`define CSP_C1_SOFT_PDOWN 6
`define CSP_C1_FMT_15P1   0

// Control register 3 fields
`define CSP_C3_SLAVES_HI  7
`define CSP_C3_SLAVES_LO  6
`define CSP_C3_FSD_HI     5
`define CSP_C3_FSD_LO     0

// Secondary word fields
`define CSP_SEC_RW_BIT    13
`define CSP_SEC_ADDR_HI   12
`define CSP_SEC_ADDR_LO   8

// Reset values
`define CSP_REG_RESET     8'h00
`define CSP_SYNC_INIT     7'h32

// Timing counts
`define CSP_RST_MIN_MCLK  6
`define CSP_WORD_BITS     16
`define CSP_SEC_SLOT      8'h80
`define CSP_SEC_SLOT_END  8'h90
`define CSP_FSD_MIN_DELAY 6'h11
`define CSP_SCLK_HALF     4

`endif

// File: design/csp_pkg.sv
package csp_pkg;

  typedef enum logic [2:0] {
    CSP_IDLE  = 3'b001,
    CSP_SHIFT = 3'b010,
    CSP_DONE  = 3'b100
  } csp_frame_t;

  typedef enum logic [1:0] {
    CSP_PRIMARY   = 2'b01,
    CSP_SECONDARY = 2'b10
  } csp_kind_t;

endpackage

// File: design/csp_fifo.sv
`timescale 1ns/1ns
module csp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  input  wire logic             i_clear,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic      [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             do_wr;
  logic             do_rd;

  always_comb begin
    do_wr       = i_wr_valid && o_wr_ready;
    do_rd       = i_rd_ready && o_rd_valid;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (i_clear) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end else begin
      if (do_wr) begin
        next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        next_count = count + 1'b1;
      end else if (do_rd && !do_wr) begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      o_wr_ready <= 1'b1;
      o_rd_valid <= 1'b0;
    end else begin
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      count      <= next_count;
      o_wr_ready <= (next_count != (AW+1)'(DEPTH));
      o_rd_valid <= (next_count != '0);
    end
  end

  // Storage has no reset; validity is carried by the count alone
  always_ff @(posedge i_mclk) begin
    if (do_wr && !i_clear) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  assign o_rd_data = mem[rd_ptr];
endmodule

// File: verification/csp_serial_port_asserts.sv
`timescale 1ns/1ns
module csp_serial_port_asserts #(
  parameter int SCLK_HALF = 4
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_power_down_n,
  input wire logic i_master_sel,
  input wire logic o_sclk,
  input wire logic o_sclk_oe,
  input wire logic o_frame_sync_n,
  input wire logic o_frame_sync_oe,
  input wire logic o_dout_oe,
  input wire logic o_delayed_frame_sync_n,
  input wire logic o_soft_power_down,
  input wire logic o_analog_enable
);
  localparam int FRAME_MCLK = 32 * SCLK_HALF;
  logic [15:0] low_cnt;
  logic [15:0] next_low_cnt;

  always_comb begin
    next_low_cnt = o_frame_sync_n ? 16'h0000 : low_cnt + 16'h0001;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      low_cnt <= 16'h0000;
    end else begin
      low_cnt <= next_low_cnt;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  // Sclk high excludes a sync cut short by an internal reset
  sequence s_frame_start;
    $fell(o_frame_sync_n) && o_frame_sync_oe && o_sclk;
  endsequence
  sequence s_frame_end;
    $rose(o_frame_sync_n) && o_frame_sync_oe && o_sclk;
  endsequence

  a_sync_release: assert property (s_frame_end |-> ##[1:3] !o_dout_oe)
    else $error("dout still driven after sync rise");
  a_idle_quiet: assert property ((o_sclk_oe && o_frame_sync_n) [*5] |-> !o_dout_oe)
    else $error("dout driven outside own frame");
  a_sync_on_rise: assert property ($fell(o_frame_sync_n) && o_frame_sync_oe |-> o_sclk)
    else $error("sync fell away from sclk rise");
  a_frame_length: assert property (s_frame_end |-> low_cnt == FRAME_MCLK)
    else $error("sync low time not 16 sclk periods");
  a_soft_quiet: assert property (o_soft_power_down [*8] |->
    !o_dout_oe && o_delayed_frame_sync_n)
    else $error("outputs active in soft power-down");
  a_analog_off: assert property (o_soft_power_down [*2] |-> !o_analog_enable)
    else $error("analog on in soft power-down");
  a_slave_inputs: assert property ((!i_master_sel) [*6] |->
    !o_sclk_oe && !o_frame_sync_oe)
    else $error("slave drives sclk or sync");
  a_fsd_start: assert property (s_frame_start ##0 !o_soft_power_down |->
    ##[0:3] !o_delayed_frame_sync_n)
    else $error("delayed sync missing at frame start");
  a_hard_freeze: assert property ((!i_power_down_n) [*8] |->
    $stable(o_sclk) && $stable(o_frame_sync_n) && !o_analog_enable)
    else $error("activity in hardware power-down");
endmodule

bind csp_serial_port csp_serial_port_asserts #(.SCLK_HALF(SCLK_HALF)) csp_serial_port_asserts_i (
  .i_mclk, .i_reset, .i_power_down_n, .i_master_sel, .o_sclk, .o_sclk_oe, .o_frame_sync_n,
  .o_frame_sync_oe, .o_dout_oe, .o_delayed_frame_sync_n, .o_soft_power_down, .o_analog_enable);

// File: verification/csp_dsp_model.sv
`timescale 1ns/1ns
module csp_dsp_model (
  input  wire logic        i_sclk,
  input  wire logic        i_frame_sync_n,
  input  wire logic        i_dout,
  input  wire logic        i_dout_oe,
  input  wire logic [15:0] i_tx_word,
  output logic             o_din,
  output logic      [15:0] o_rx_word,
  output logic      [4:0]  o_oe_cnt,
  output int               o_frames
);
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic [4:0]  n_bits;
  logic [4:0]  n_oe;

  initial begin
    o_din = 1'b0;
    o_rx_word = 16'h0000;
    o_oe_cnt = 5'h00;
    o_frames = 0;
  end

  // Shifting starts at the sync fall, MSB first
  always @(negedge i_frame_sync_n) begin
    o_din = i_tx_word[15];
    tx_sh = {i_tx_word[14:0], 1'b0};
    n_bits = 5'h00;
    n_oe = 5'h00;
  end

  always @(posedge i_sclk) begin
    if (!i_frame_sync_n && n_bits != 5'h00 && n_bits < 5'h10) begin
      o_din = tx_sh[15];
      tx_sh = {tx_sh[14:0], 1'b0};
    end
  end

  always @(negedge i_sclk) begin
    if (!i_frame_sync_n && n_bits < 5'h10) begin
      rx_sh = {rx_sh[14:0], i_dout_oe ? i_dout : !i_dout};
      n_oe = n_oe + {4'h0, i_dout_oe};
      n_bits = n_bits + 5'h01;
      if (n_bits == 5'h10) begin
        o_rx_word = rx_sh;
        o_oe_cnt = n_oe;
        o_frames = o_frames + 1;
      end
    end
  end

  // Released data line shows the inverse of its last bit, never a held value
  always @(posedge i_frame_sync_n) begin
    o_din = ~o_din;
  end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ns
module tb;
  logic        i_mclk, i_reset, i_power_down_n, i_master_sel, i_din;
  logic        i_secondary_request_in, i_dac_ready, tb_sclk, tb_fs_n, rst_pin_n;
  logic [15:0] i_adc_sample, dsp_tx, dsp_rx, rxw, o_dac_data;
  logic        o_sclk, o_sclk_oe, o_frame_sync_n, o_frame_sync_oe, o_dout, o_dout_oe;
  logic        o_delayed_frame_sync_n, o_dac_valid, o_dac_overrun;
  logic        o_soft_power_down, o_analog_enable;
  logic [4:0]  oe_cnt;
  int          frames, n_fail, cmp_count, k, f0;
  logic [15:0] dac_q[$];
  wire logic   sclk_w = o_sclk_oe ? o_sclk : tb_sclk;
  wire logic   fs_w = o_frame_sync_oe ? o_frame_sync_n : tb_fs_n;

  csp_serial_port #(.SCLK_HALF(4), .FIFO_DEPTH(8)) csp_serial_port_i (
    .i_mclk, .i_reset, .i_reset_pin_n(rst_pin_n), .i_power_down_n, .i_master_sel,
    .i_sclk(sclk_w), .i_frame_sync_n(fs_w), .i_din, .i_secondary_request_in,
    .i_adc_sample, .i_dac_ready, .o_sclk, .o_sclk_oe, .o_frame_sync_n, .o_frame_sync_oe,
    .o_dout, .o_dout_oe, .o_delayed_frame_sync_n, .o_dac_data, .o_dac_valid,
    .o_dac_overrun, .o_soft_power_down, .o_analog_enable);

  csp_dsp_model csp_dsp_model_i (.i_sclk(sclk_w), .i_frame_sync_n(fs_w), .i_dout(o_dout),
    .i_dout_oe(o_dout_oe), .i_tx_word(dsp_tx), .o_din(i_din), .o_rx_word(dsp_rx),
    .o_oe_cnt(oe_cnt), .o_frames(frames));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    if (o_dac_valid && i_dac_ready) begin
      dac_q.push_back(o_dac_data);
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("Compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // One frame with the far end; req drives the hardware request line
  task automatic xfer(input logic [15:0] tx, input logic req, output logic [15:0] rx);
    int n0;
    n0 = frames;
    dsp_tx = tx;
    i_secondary_request_in = req;
    for (int i = 0; i < 3000 && frames == n0; i++) cyc(1);
    if (frames == n0) begin
      n_fail++;
      test_done();
    end
    rx = dsp_rx;
    cyc(8);
    i_secondary_request_in = 1'b0;
  endtask

  function automatic logic [15:0] sw(input logic rd, input logic [4:0] a, input logic [7:0] d);
    return {2'b00, rd, a, d};
  endfunction

  initial begin
    i_reset = 1'b1;
    i_power_down_n = 1'b1;
    rst_pin_n = 1'b1;
    i_master_sel = 1'b1;
    i_secondary_request_in = 1'b0;
    i_dac_ready = 1'b1;
    i_adc_sample = 16'ha5c2;
    dsp_tx = 16'h0000;
    tb_sclk = 1'b0;
    tb_fs_n = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    cyc(3);
    i_reset = 1'b0;
    xfer(16'h1234, 1'b0, rxw);
    check("primary out", 16'ha5c3, rxw);
    check("driven bits", 16'h0010, {11'h000, oe_cnt});
    check("dac word", 16'h1234, dac_q.pop_front());
    xfer(16'h5678, 1'b1, rxw);
    xfer(sw(1'b0, 5'h01, 8'h01), 1'b0, rxw);
    check("write reply", 16'h8000, rxw);
    xfer(16'h4441, 1'b0, rxw);
    xfer(sw(1'b1, 5'h01, 8'h00), 1'b0, rxw);
    check("read ctrl1", 16'h8001, rxw);
    xfer(16'h7770, 1'b0, rxw);
    xfer(16'h3332, 1'b0, rxw);
    check("dac a", 16'h5678, dac_q.pop_front());
    check("dac b", 16'h4440, dac_q.pop_front());
    check("dac c", 16'h7770, dac_q.pop_front());
    check("dac d", 16'h3332, dac_q.pop_front());
    $display("test frames done");
    xfer(16'h0001, 1'b0, rxw);
    xfer(sw(1'b0, 5'h01, 8'h41), 1'b0, rxw);
    cyc(2);
    check("soft pd", 16'h0001, {15'h0000, o_soft_power_down});
    check("analog off", 16'h0000, {15'h0000, o_analog_enable});
    dac_q.delete();
    xfer(16'h2220, 1'b1, rxw);
    check("pd driven bits", 16'h0000, {11'h000, oe_cnt});
    check("pd pushes", 16'h0000, 16'(dac_q.size()));
    xfer(sw(1'b0, 5'h01, 8'h01), 1'b0, rxw);
    cyc(2);
    check("pd cleared", 16'h0000, {15'h0000, o_soft_power_down});
    check("analog on", 16'h0001, {15'h0000, o_analog_enable});
    $display("test soft power-down done");
    xfer(16'h0001, 1'b0, rxw);
    xfer(sw(1'b0, 5'h01, 8'h81), 1'b0, rxw);
    cyc(20);
    xfer(16'h0000, 1'b1, rxw);
    xfer(sw(1'b1, 5'h01, 8'h00), 1'b0, rxw);
    check("ctrl1 after reset", 16'h8000, rxw);
    xfer(16'h0000, 1'b1, rxw);
    xfer(sw(1'b0, 5'h01, 8'h01), 1'b0, rxw);
    rst_pin_n = 1'b0;
    cyc(8);
    rst_pin_n = 1'b1;
    cyc(20);
    xfer(16'h0000, 1'b1, rxw);
    xfer(sw(1'b1, 5'h01, 8'h00), 1'b0, rxw);
    check("ctrl1 after pin reset", 16'h8000, rxw);
    $display("test soft reset done");
    i_dac_ready = 1'b0;
    cyc(4);
    dac_q.delete();
    for (k = 0; k < 10; k++) begin
      xfer({8'h10, k[6:0], 1'b0}, 1'b0, rxw);
      if (k == 8) check("no overrun", 16'h0000, {15'h0000, o_dac_overrun});
    end
    check("overrun", 16'h0001, {15'h0000, o_dac_overrun});
    i_dac_ready = 1'b1;
    cyc(30);
    check("drained", 16'h0009, 16'(dac_q.size()));
    check("first kept", 16'h1000, dac_q[0]);
    check("last kept", 16'h1010, dac_q[8]);
    $display("test buffer done");
    i_power_down_n = 1'b0;
    f0 = frames;
    cyc(4200);
    check("frozen frames", 16'(f0), 16'(frames));
    check("analog off hw", 16'h0000, {15'h0000, o_analog_enable});
    i_power_down_n = 1'b1;
    xfer(16'h5550, 1'b0, rxw);
    check("after wake", 16'ha5c3, rxw);
    $display("test hardware power-down done");
    i_master_sel = 1'b0;
    cyc(10);
    check("sclk oe", 16'h0000, {15'h0000, o_sclk_oe});
    check("sync oe", 16'h0000, {15'h0000, o_frame_sync_oe});
    f0 = frames;
    tb_sclk = 1'b1;
    cyc(1);
    tb_fs_n = 1'b0;
    cyc(3);
    for (k = 0; k < 16; k++) begin
      tb_sclk = 1'b0;
      cyc(4);
      tb_sclk = 1'b1;
      cyc(4);
    end
    tb_fs_n = 1'b1;
    cyc(3);
    tb_sclk = 1'b0;
    cyc(10);
    check("slave frame", 16'(f0 + 1), 16'(frames));
    check("slave driven", 16'h0000, {11'h000, oe_cnt});
    $display("test slave done");
    test_done();
  end
endmodule
